// *** design/wdw_watchdog.sv ***
`timescale 1ns/1ps
`default_nettype none

module wdw_watchdog #(
    parameter int unsigned TICK_CYCLES = wdw_pkg::LP_TICK_CYCLES
) (
    // clock and power-on reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // core events, one-cycle pulses
    input  wire logic        wd_clear_instr,
    input  wire logic        power_save_instr,
    input  wire logic        power_save_idle,
    input  wire logic        wake_event,
    input  wire logic        clk_switch_done,
    input  wire logic        dev_reset_in,
    // status to the core
    output logic             wd_reset_req,
    output logic             wd_wake,
    output logic             low_power_rc_osc_en,
    output logic             in_low_power
);

    localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [wdw_pkg::POST_W-1:0] post_last(input logic [3:0] sel);
        post_last = wdw_pkg::POST_W'((32'h1 << sel) - 32'h1);
    endfunction

    function automatic logic [wdw_pkg::PRE_W-1:0] pre_last(input logic long_sel);
        pre_last = long_sel ? wdw_pkg::PRE_W'(wdw_pkg::PRE_DIV_LONG - 1)
                            : wdw_pkg::PRE_W'(wdw_pkg::PRE_DIV_SHORT - 1);
    endfunction

    // true once three quarters of the period have elapsed
    function automatic logic win_open(input logic [wdw_pkg::POST_W-1:0] post,
                                      input logic [wdw_pkg::PRE_W-1:0]  pre,
                                      input wdw_pkg::wdw_fuse_t         f);
        logic [wdw_pkg::ELAPSED_W-1:0] elapsed;
        logic [wdw_pkg::ELAPSED_W-1:0] thresh;
        int unsigned                   e;
        e = 32'(f.wd_postscale_ratio) +
            (f.wd_prescale_select ? wdw_pkg::PRE_LOG_LONG : wdw_pkg::PRE_LOG_SHORT);
        elapsed = f.wd_prescale_select ? {1'b0, post, pre}
                                       : {3'b000, post, pre[4:0]};
        thresh = wdw_pkg::ELAPSED_W'(64'd3 << (e - 2));
        win_open = elapsed >= thresh;
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    wdw_pkg::wdw_fuse_t          fuse_q;
    logic                        fuse_locked_q;
    wdw_pkg::wdw_rstctl_t        rstctl_q;
    wdw_pkg::wdw_pwr_t           pwr_q;
    wdw_pkg::wdw_pwr_t           pwr_d;
    logic [TW-1:0]               tick_cnt_q;
    logic [wdw_pkg::PRE_W-1:0]   pre_cnt_q;
    logic [wdw_pkg::POST_W-1:0]  post_cnt_q;
    logic                        ack_q;
    logic [31:0]                 rdata_q;

    logic wd_run;
    logic lp_tick;
    logic pre_tick;
    logic timeout;
    logic fire;
    logic wake_evt;
    logic enter_ps;
    logic clr_ok;
    logic dev_rst_evt;
    logic clear_all;
    logic req;
    logic wr_acc;
    logic wr_fuse;
    logic wr_rstctl;

    // ****************************************************************
    // enable and event decode
    // ****************************************************************
    assign wd_run              = fuse_q.wd_enable_fuse | rstctl_q.wd_soft_enable;
    assign low_power_rc_osc_en = wd_run;
    assign in_low_power        = (pwr_q != wdw_pkg::WDW_RUN);

    assign lp_tick  = wd_run && (tick_cnt_q == TW'(TICK_CYCLES - 1));
    assign pre_tick = lp_tick && (pre_cnt_q == pre_last(fuse_q.wd_prescale_select));
    assign timeout  = pre_tick && (post_cnt_q == post_last(fuse_q.wd_postscale_ratio));

    // a clear outside the last quarter in window mode is a fault
    assign clr_ok = wd_clear_instr && !in_low_power &&
                    (fuse_q.window_disable_fuse ||
                     win_open(post_cnt_q, pre_cnt_q, fuse_q));
    assign fire = !in_low_power && (timeout ||
                  (wd_run && wd_clear_instr && !clr_ok));
    assign wake_evt    = in_low_power && (timeout || wake_event);
    assign enter_ps    = !in_low_power && power_save_instr && !fire;
    assign dev_rst_evt = dev_reset_in || fire;
    assign clear_all   = dev_rst_evt || clk_switch_done || enter_ps ||
                         wake_evt || clr_ok;

    // ****************************************************************
    // oscillator tick divider
    // ****************************************************************
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_q <= '0;
        end else if (!wd_run || lp_tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + TW'(1);
        end
    end

    // ****************************************************************
    // prescaler and postscaler
    // ****************************************************************
    // counting does not look at the power state, so sleep and idle keep running
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_cnt_q  <= '0;
            post_cnt_q <= '0;
        end else if (clear_all) begin
            pre_cnt_q  <= '0;
            post_cnt_q <= '0;
        end else if (pre_tick) begin
            pre_cnt_q  <= '0;
            post_cnt_q <= post_cnt_q + wdw_pkg::POST_W'(1);
        end else if (lp_tick) begin
            pre_cnt_q  <= pre_cnt_q + wdw_pkg::PRE_W'(1);
        end
    end

    // ****************************************************************
    // power state
    // ****************************************************************
    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            wdw_pkg::WDW_RUN: begin
                if (dev_rst_evt) begin
                    pwr_d = wdw_pkg::WDW_RUN;
                end else if (enter_ps) begin
                    pwr_d = power_save_idle ? wdw_pkg::WDW_IDLE : wdw_pkg::WDW_SLEEP;
                end
            end
            wdw_pkg::WDW_SLEEP,
            wdw_pkg::WDW_IDLE: begin
                if (dev_rst_evt || wake_evt) begin
                    pwr_d = wdw_pkg::WDW_RUN;
                end
            end
            default: begin
                pwr_d = wdw_pkg::WDW_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwr_q <= wdw_pkg::WDW_RUN;
        end else begin
            pwr_q <= pwr_d;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wd_reset_req <= 1'b0;
            wd_wake      <= 1'b0;
        end else begin
            wd_reset_req <= fire;
            wd_wake      <= wake_evt && !dev_reset_in;
        end
    end

    // ****************************************************************
    // avalon-mm slave: one wait cycle, then the answer
    // ****************************************************************
    assign req             = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_q;
    assign avs_readdata    = rdata_q;
    assign wr_acc          = avs_write && ack_q && avs_byteenable[0];
    assign wr_fuse         = wr_acc && (avs_address == wdw_pkg::FUSE_OFS);
    assign wr_rstctl       = wr_acc && (avs_address == wdw_pkg::RSTCTL_OFS);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    // unmapped addresses read zero and ignore writes
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= '0;
        end else if (avs_read && !ack_q) begin
            rdata_q <= '0;
            case (avs_address)
                wdw_pkg::FUSE_OFS: begin
                    rdata_q[7:0] <= fuse_q;
                end
                wdw_pkg::RSTCTL_OFS: begin
                    rdata_q[wdw_pkg::RSTCTL_SWEN_BIT:wdw_pkg::RSTCTL_IDLE_BIT] <= rstctl_q;
                end
                wdw_pkg::STAT_OFS: begin
                    rdata_q[wdw_pkg::POST_W-1:0] <= post_cnt_q;
                    rdata_q[wdw_pkg::STAT_PRE_LSB +: wdw_pkg::PRE_W] <= pre_cnt_q;
                    rdata_q[wdw_pkg::STAT_PWR_LSB +: 2] <= pwr_q;
                    rdata_q[wdw_pkg::STAT_RUN_BIT] <= wd_run;
                end
                default: begin
                    rdata_q <= '0;
                end
            endcase
        end
    end

    // ****************************************************************
    // fuse register: write-once until power-on reset
    // ****************************************************************
    // a device reset leaves the fuses alone, as configuration outlives it
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fuse_q        <= wdw_pkg::FUSE_RESET;
            fuse_locked_q <= 1'b0;
        end else if (wr_fuse && !fuse_locked_q) begin
            fuse_q        <= avs_writedata[7:0] & wdw_pkg::FUSE_MASK;
            fuse_locked_q <= 1'b1;
        end
    end

    // ****************************************************************
    // reset-control bits: hardware set or clear wins over software write
    // ****************************************************************
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstctl_q <= '0;
        end else begin
            if (dev_rst_evt) begin
                rstctl_q.wd_soft_enable <= 1'b0;
            end else if (wr_rstctl) begin
                rstctl_q.wd_soft_enable <= avs_writedata[wdw_pkg::RSTCTL_SWEN_BIT];
            end
            if (fire) begin
                rstctl_q.wd_timeout_flag <= 1'b1;
            end else if (wr_rstctl) begin
                rstctl_q.wd_timeout_flag <= avs_writedata[wdw_pkg::RSTCTL_TO_BIT];
            end
            // flags are left for software to clear after wake-up
            if (enter_ps && !power_save_idle) begin
                rstctl_q.sleep_flag <= 1'b1;
            end else if (wr_rstctl) begin
                rstctl_q.sleep_flag <= avs_writedata[wdw_pkg::RSTCTL_SLP_BIT];
            end
            if (enter_ps && power_save_idle) begin
                rstctl_q.idle_flag <= 1'b1;
            end else if (wr_rstctl) begin
                rstctl_q.idle_flag <= avs_writedata[wdw_pkg::RSTCTL_IDLE_BIT];
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    localparam int PRE_SHORT_LAST = int'(wdw_pkg::PRE_DIV_SHORT) - 1;
    localparam int PRE_LONG_LAST  = int'(wdw_pkg::PRE_DIV_LONG) - 1;

    osc_forced_on_a: assert property (
        fuse_q.wd_enable_fuse |-> low_power_rc_osc_en)
        else $error("oscillator off while enable fuse set");

    pre_ratio_a: assert property (
        pre_tick |-> pre_cnt_q == (fuse_q.wd_prescale_select ? PRE_LONG_LAST : PRE_SHORT_LAST))
        else $error("prescaler wrapped at wrong count");

    clear_counts_a: assert property (
        clear_all |=> (pre_cnt_q == 0) && (post_cnt_q == 0))
        else $error("counts not cleared after clear event");

    run_timeout_a: assert property (
        (timeout && !in_low_power) |=> wd_reset_req && rstctl_q.wd_timeout_flag && !wd_wake)
        else $error("run time-out did not reset and flag");

    sleep_wake_a: assert property (
        (timeout && in_low_power && !dev_reset_in) |=> wd_wake && !wd_reset_req
                                                       && (pwr_q == wdw_pkg::WDW_RUN))
        else $error("low-power time-out did not wake cleanly");

    soft_en_reset_a: assert property (
        dev_rst_evt |=> !rstctl_q.wd_soft_enable)
        else $error("soft enable survived device reset");

    flag_sticky_a: assert property (
        (rstctl_q.wd_timeout_flag && !wr_rstctl) |=> rstctl_q.wd_timeout_flag)
        else $error("time-out flag dropped without software");

    early_clear_a: assert property (
        (wd_run && wd_clear_instr && !in_low_power && !fuse_q.window_disable_fuse
         && !win_open(post_cnt_q, pre_cnt_q, fuse_q)) |=> wd_reset_req)
        else $error("early clear in window mode did not reset");

    halted_hold_a: assert property (
        (!wd_run && !clear_all) |=> $stable(post_cnt_q) && $stable(pre_cnt_q))
        else $error("disabled watchdog counted");

    sleep_count_a: assert property (
        (in_low_power && lp_tick && !clear_all && !pre_tick) |=> pre_cnt_q == $past(pre_cnt_q) + 1)
        else $error("prescaler stalled in low power");

    avalon_wait_a: assert property (
        (req && !ack_q) |=> (!avs_waitrequest || !req))
        else $error("waitrequest held more than one cycle");

    cov_run_reset_c:  cover property (timeout && !in_low_power);
    cov_sleep_wake_c: cover property (timeout && pwr_q == wdw_pkg::WDW_SLEEP);
    cov_window_ok_c:  cover property (clr_ok && !fuse_q.window_disable_fuse);
    cov_early_clr_c:  cover property (fire && wd_clear_instr);

endmodule // wdw_watchdog

`default_nettype wire

// *** design/wdw_pkg.sv ***
`default_nettype none

package wdw_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned CORE_CLK_HZ    = 25_000_000;
    localparam int unsigned LP_OSC_HZ      = 32_000;
    // core cycles per nominal low-power oscillator period, rounded down
    localparam int unsigned LP_TICK_CYCLES = CORE_CLK_HZ / LP_OSC_HZ;
    localparam int unsigned PRE_DIV_SHORT  = 32;
    localparam int unsigned PRE_DIV_LONG   = 128;
    localparam int unsigned PRE_LOG_SHORT  = 5;
    localparam int unsigned PRE_LOG_LONG   = 7;
    // nominal base period after the prescaler, in microseconds
    localparam int unsigned BASE_US_SHORT  = 1000;
    localparam int unsigned BASE_US_LONG   = 4000;
    localparam int unsigned PRE_W          = 7;
    localparam int unsigned POST_W         = 15;
    localparam int unsigned ELAPSED_W      = PRE_W + POST_W + 1;

    // ****************************************************************
    // register map (byte addresses, one 32-bit word each)
    // ****************************************************************
    localparam logic [3:0]  FUSE_OFS      = 4'h0;
    localparam logic [3:0]  RSTCTL_OFS      = 4'h4;
    localparam logic [3:0]  STAT_OFS        = 4'h8;
    localparam int unsigned RSTCTL_IDLE_BIT = 2;
    localparam int unsigned RSTCTL_SLP_BIT  = 3;
    localparam int unsigned RSTCTL_TO_BIT   = 4;
    localparam int unsigned RSTCTL_SWEN_BIT = 5;
    localparam int unsigned STAT_PRE_LSB  = 16;
    localparam int unsigned STAT_PWR_LSB  = 24;
    localparam int unsigned STAT_RUN_BIT  = 28;
    // unprogrammed fuses read as one; bit 5 is not implemented
    localparam logic [7:0]  FUSE_RESET    = 8'hdf;
    localparam logic [7:0]  FUSE_MASK     = 8'hdf;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic       wd_enable_fuse;
        logic       window_disable_fuse;
        logic       unused;
        logic       wd_prescale_select;
        logic [3:0] wd_postscale_ratio;
    } wdw_fuse_t;

    typedef struct packed {
        logic wd_soft_enable;
        logic wd_timeout_flag;
        logic sleep_flag;
        logic idle_flag;
    } wdw_rstctl_t;

    typedef enum logic [1:0] {
        WDW_RUN   = 2'b00,
        WDW_SLEEP = 2'b01,
        WDW_IDLE  = 2'b10
    } wdw_pwr_t;

endpackage

`default_nettype wire

// *** dv/wdw_watchdog_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module wdw_watchdog_bench;

    // ****************************************************************
    // signals
    // ****************************************************************
    // a short lp tick keeps the longest period near one thousand cycles
    localparam int TICK = 2;
    logic        core_clk      = 1'b0;
    logic        reset_n       = 1'b0;
    logic [3:0]  avs_address   = 4'h0;
    logic        avs_read      = 1'b0;
    logic        avs_write     = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [4:0]  ev            = 5'h0;
    logic        ps_idle       = 1'b0;
    logic        wd_reset_req;
    logic        wd_wake;
    logic        osc_en;
    logic        in_low_power;
    int          errors          = 0;
    int          samples_checked = 0;
    int          rst_cnt         = 0;
    int          n;
    int          p;
    int          r0;
    logic [31:0] q;
    logic [7:0]  f;

    always #20 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (wd_reset_req === 1'b1) begin
            rst_cnt++;
        end
    end

    wdw_watchdog #(.TICK_CYCLES(TICK)) dut_u (
        .core_clk            (core_clk),
        .reset_n             (reset_n),
        .avs_address         (avs_address),
        .avs_read            (avs_read),
        .avs_write           (avs_write),
        .avs_writedata       (avs_writedata),
        .avs_byteenable      (4'hf),
        .avs_readdata        (avs_readdata),
        .avs_waitrequest     (avs_waitrequest),
        .wd_clear_instr      (ev[0]),
        .power_save_instr    (ev[1]),
        .power_save_idle     (ps_idle),
        .wake_event          (ev[2]),
        .clk_switch_done     (ev[3]),
        .dev_reset_in        (ev[4]),
        .wd_reset_req        (wd_reset_req),
        .wd_wake             (wd_wake),
        .low_power_rc_osc_en (osc_en),
        .in_low_power        (in_low_power)
    );

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(input logic c, input string m);
        samples_checked++;
        if (c !== 1'b1) begin
            errors++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask

    task automatic summarize();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] rq);
        int k;
        k = 0;
        @(posedge core_clk);
        avs_address   <= a;
        avs_read      <= ~w;
        avs_write     <= w;
        avs_writedata <= d;
        do begin
            @(posedge core_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        rq = avs_readdata;
        if (k >= 50) begin
            chk(1'b0, "bus answer missing");
        end
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(a, 1'b1, d, dummy);
    endtask

    task automatic pulse(input int k);
        @(posedge core_clk);
        ev <= 5'(1 << k);
        @(posedge core_clk);
        ev <= 5'h0;
    endtask

    // cycles until wd_reset_req (s=0) or wd_wake (s=1) is seen
    task automatic wait_evt(input int s, input int lim, output int k);
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (((s == 0) ? wd_reset_req : wd_wake) !== 1'b1 && k < lim);
    endtask

    function automatic int period(input logic pre, input logic [3:0] r);
        return TICK * (pre ? 128 : 32) * (1 << r);
    endfunction

    function automatic logic near(input int k, input int e);
        return (k >= e - 6) && (k <= e + 8);
    endfunction

    // fuses are write-once, so each setting starts from a fresh reset_n
    task automatic cfg(input logic [7:0] fv);
        reset_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        wr(wdw_pkg::FUSE_OFS, {24'h0, fv});
    endtask

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        #(40 * 60000);
        errors++;
        summarize();
    end

    initial begin
        r0 = $urandom(42);
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        bus(wdw_pkg::FUSE_OFS, 1'b0, 32'h0, q);
        chk(q === {24'h0, wdw_pkg::FUSE_RESET}, "fuse reset value");
        bus(wdw_pkg::RSTCTL_OFS, 1'b0, 32'h0, q);
        chk(q === 32'h0, "reset-control reset value");
        chk(osc_en === 1'b1, "osc on with fuse enable");
        wr(4'hc, 32'hffff_ffff);
        bus(4'hc, 1'b0, 32'h0, q);
        chk(q === 32'h0, "unmapped reads zero");

        // software enable only
        cfg(8'h40);
        wr(wdw_pkg::FUSE_OFS, 32'hc0);
        bus(wdw_pkg::FUSE_OFS, 1'b0, 32'h0, q);
        chk(q === 32'h40, "fuse write once");
        chk(osc_en === 1'b0, "osc off without enable");
        n = rst_cnt;
        repeat (200) @(posedge core_clk);
        chk(rst_cnt == n, "disabled watchdog fired");
        wr(wdw_pkg::RSTCTL_OFS, 32'h20);
        // the write lands at the edge the task returns on
        @(negedge core_clk);
        chk(osc_en === 1'b1, "soft enable starts osc");
        wait_evt(0, 400, n);
        chk(near(n, period(1'b0, 4'h0)), "soft enable period");
        bus(wdw_pkg::RSTCTL_OFS, 1'b0, 32'h0, q);
        chk((q[7:0] & 8'h3c) === 8'h10, "flag set, soft enable cleared");

        // random prescale and postscale settings under the enable fuse
        repeat (4) begin
            f = {2'b11, 1'b0, 1'($urandom % 2), 4'($urandom % 3)};
            cfg(f);
            pulse(3);
            p = period(f[4], f[3:0]);
            chk(osc_en === 1'b1, "fuse keeps osc on");
            wait_evt(0, p + 40, n);
            chk(near(n, p), "fuse period");
            bus(wdw_pkg::FUSE_OFS, 1'b0, 32'h0, q);
            chk(q === {24'h0, f & wdw_pkg::FUSE_MASK}, "fuse readback");
        end

        // the clear instruction, clock switch and device reset each restart the count
        cfg(8'hc0);
        pulse(3);
        for (int k = 0; k < 5; k++) begin
            if (k == 1 || k == 2) begin
                continue;
            end
            repeat (40) @(posedge core_clk);
            pulse(k);
            wait_evt(0, 200, n);
            chk(near(n, 64), "clear restarts count");
        end

        // sleep or idle keeps counting and wakes instead of resetting
        repeat (20) @(posedge core_clk);
        ps_idle <= 1'($urandom % 2);
        pulse(1);
        // the power state updates at the edge the pulse task returns on
        @(negedge core_clk);
        chk(in_low_power === 1'b1, "low power entered");
        n = rst_cnt;
        wait_evt(1, 200, p);
        chk(near(p, 64), "wake period");
        chk(rst_cnt == n, "no reset while asleep");
        @(negedge core_clk);
        chk(in_low_power === 1'b0, "left low power");
        bus(wdw_pkg::RSTCTL_OFS, 1'b0, 32'h0, q);
        chk(q[ps_idle ? 2 : 3] === 1'b1, "low power flag");
        wr(wdw_pkg::RSTCTL_OFS, 32'h0);
        bus(wdw_pkg::RSTCTL_OFS, 1'b0, 32'h0, q);
        chk(q[5:2] === 4'h0, "software clears flags");
        pulse(1);
        repeat (30) @(posedge core_clk);
        pulse(2);
        wait_evt(0, 200, n);
        chk(near(n, 64), "leaving low power clears");

        // window mode: early clear resets, late clear only restarts
        cfg(8'h81);
        pulse(3);
        repeat (20) @(posedge core_clk);
        pulse(0);
        wait_evt(0, 6, n);
        chk(wd_reset_req === 1'b1, "early clear resets");
        bus(wdw_pkg::RSTCTL_OFS, 1'b0, 32'h0, q);
        chk(q[4] === 1'b1, "early clear sets flag");
        wait_evt(0, 300, n);
        repeat (100) @(posedge core_clk);
        n = rst_cnt;
        pulse(0);
        // a wrongful reset would only be counted one edge later
        @(posedge core_clk);
        @(negedge core_clk);
        chk(rst_cnt == n, "late clear accepted");
        wait_evt(0, 300, n);
        chk(near(n, 128), "late clear restarts count");
        summarize();
    end

endmodule // wdw_watchdog_bench

`default_nettype wire
